// ---- design/wdt_tb_pkg.sv ----
package wdt_tb_pkg;
    // register indices; one of them is not word aligned, so each index is one aligned word
    localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'h24;
    localparam logic [7:0] IDX_TIMEBASE_CTRL_STS = 8'h26;
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h28;
    // axi4-lite byte address is four times the index
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL = {IDX_WATCHDOG_CONTROL[5:0], 2'b00};
    localparam logic [7:0] ADDR_TIMEBASE_CTRL_STS = {IDX_TIMEBASE_CTRL_STS[5:0], 2'b00};
    localparam logic [7:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL[5:0], 2'b00};
    // watchdog_control fields
    localparam int WDG_ACTIVATE_BIT = 7;
    localparam int WDG_MSB_BIT = 6;
    localparam logic [7:0] WDG_CTRL_RESET = 8'h7f;
    localparam logic [6:0] WDG_EXPIRE_FROM = 7'h40;
    localparam int WDG_STEP_CYCLES = 16384;
    // timebase_control_status fields
    localparam int TB_FLAG_BIT = 0;
    localparam int TB_IRQ_EN_BIT = 1;
    localparam int TB_SEL_LSB = 2;
    localparam logic [7:0] TB_CSR_RESET = 8'h00;
    localparam int TB_PRESCALE_0 = 16000;
    localparam int TB_PRESCALE_1 = 32000;
    localparam int TB_PRESCALE_2 = 80000;
    localparam int TB_PRESCALE_3 = 200000;
    localparam int TB_CNT_W = 18;
    // power_control fields (write-only commands, read back mode)
    localparam int PWR_HALT_BIT = 0;
    localparam int PWR_WAIT_BIT = 1;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        PM_RUN,
        PM_WAIT,
        PM_TIMED_SLEEP,
        PM_HALT
    } power_mode_t;
endpackage

// ---- design/timebase_divider.sv ----
`timescale 1ns/10ps
module timebase_divider
    import wdt_tb_pkg::*;
#(
    parameter int P0 = TB_PRESCALE_0,
    parameter int P1 = TB_PRESCALE_1,
    parameter int P2 = TB_PRESCALE_2,
    parameter int P3 = TB_PRESCALE_3
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_run,
    input  wire logic [1:0] i_select,
    output logic            o_elapsed
);
    function automatic logic [TB_CNT_W-1:0] period_of(input logic [1:0] s);
        case (s)
            2'b00:   period_of = TB_CNT_W'(P0 - 1);
            2'b01:   period_of = TB_CNT_W'(P1 - 1);
            2'b10:   period_of = TB_CNT_W'(P2 - 1);
            default: period_of = TB_CNT_W'(P3 - 1);
        endcase
    endfunction

    logic [TB_CNT_W-1:0] count;
    logic [1:0]          active_sel;
    wire                 at_end = (count == period_of(active_sel));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count      <= '0;
            active_sel <= 2'b00;
            o_elapsed  <= 1'b0;
        end else begin
            o_elapsed <= i_run & at_end;
            if (i_run) begin
                if (at_end) begin
                    count      <= '0;
                    active_sel <= i_select;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

// ---- design/watchdog_timebase.sv ----
// How it works
// - hardware watchdog option keeps watchdog always active, activate bit ignored.
// - watchdog control resets to 7fh: inactive, countdown all ones.
// - activate bit set by software, cleared only by reset, gates watchdog resets.
// - seven-bit countdown decrements once every 16384 oscillator clock cycles while watchdog on, not in halt or timed sleep.
// - active watchdog resets system when countdown goes from 40h to 3fh.
// - four time-base periods: 16000, 32000, 80000, 200000 cycles by select bits.
// - new time-base select takes effect only after current period ends.
// - elapsed flag set on period end, cleared by reading control/status.
// - time-base interrupt only when enable set and global mask inactive.
// - halt with time-base interrupt enabled enters timed sleep, not halt.
// - wait mode leaves time-base running; its interrupt ends wait.
// - timed sleep: counter runs, time-base control writes ignored, interrupt ends sleep.
// - full halt freezes counter, time-base select and enable; watchdog control stays writable; only other wake-up ends it.
// - control/status resets to 00h; bits 7:4 read zero.
// - watchdog stays active until reset; activate with msb zero resets now.
// - halt while watchdog active resets, per halt option and irq enable.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module watchdog_timebase
    import wdt_tb_pkg::*;
#(
    parameter int WDG_STEP = WDG_STEP_CYCLES,
    parameter int PRESCALE_0 = TB_PRESCALE_0,
    parameter int PRESCALE_1 = TB_PRESCALE_1,
    parameter int PRESCALE_2 = TB_PRESCALE_2,
    parameter int PRESCALE_3 = TB_PRESCALE_3
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_hw_watchdog,
    input  wire logic        i_halt_reset_option,
    input  wire logic        i_global_irq_mask,
    input  wire logic        i_ext_wakeup,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             o_timebase_irq,
    output logic             o_reset_request,
    output logic [1:0]       o_power_mode
);
    localparam int STEP_W = $clog2(WDG_STEP);

    // pin-level inputs pass two flops
    logic [1:0] hw_sync;
    logic [1:0] hopt_sync;
    logic [1:0] mask_sync;
    logic [1:0] wake_sync;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hw_sync   <= 2'b00;
            hopt_sync <= 2'b00;
            mask_sync <= 2'b11;
            wake_sync <= 2'b00;
        end else begin
            hw_sync   <= {hw_sync[0], i_hw_watchdog};
            hopt_sync <= {hopt_sync[0], i_halt_reset_option};
            mask_sync <= {mask_sync[0], i_global_irq_mask};
            wake_sync <= {wake_sync[0], i_ext_wakeup};
        end
    end
    wire hw_wdg   = hw_sync[1];
    wire hopt     = hopt_sync[1];
    wire irq_mask = mask_sync[1];
    wire ext_wake = wake_sync[1];

    // registers
    logic              wdg_activate;
    logic [6:0]        countdown;
    logic [STEP_W-1:0] step_cnt;
    logic [1:0]        tb_select;
    logic              tb_irq_en;
    logic              tb_flag;
    power_mode_t       mode;

    // axi4-lite write side: take address and data in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire aw_now   = s_axi_awvalid && s_axi_awready;
    wire w_now    = s_axi_wvalid && s_axi_wready;
    wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire        wr_lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];
    wire wr_fire  = (aw_held || aw_now) && (w_held || w_now);
    wire wr_wdg   = wr_fire && wr_lane0 && (wr_addr == ADDR_WATCHDOG_CONTROL);
    wire wr_tb    = wr_fire && wr_lane0 && (wr_addr == ADDR_TIMEBASE_CTRL_STS);
    wire wr_pwr   = wr_fire && wr_lane0 && (wr_addr == ADDR_POWER_CONTROL);
    wire wr_known = (wr_addr == ADDR_WATCHDOG_CONTROL) || (wr_addr == ADDR_TIMEBASE_CTRL_STS)
                    || (wr_addr == ADDR_POWER_CONTROL);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? AXI_OKAY : AXI_SLVERR;
            end else begin
                if (aw_now) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_now) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // axi4-lite read side
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_tb   = rd_fire && (s_axi_araddr == ADDR_TIMEBASE_CTRL_STS);
    wire [7:0] wdg_view = {wdg_activate, countdown};
    wire [7:0] tb_view  = {4'h0, tb_select, tb_irq_en, tb_flag};
    wire [7:0] pwr_view = {6'h00, mode};
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= AXI_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            case (s_axi_araddr)
                ADDR_WATCHDOG_CONTROL:  s_axi_rdata <= {24'h0, wdg_view};
                ADDR_TIMEBASE_CTRL_STS: s_axi_rdata <= {24'h0, tb_view};
                ADDR_POWER_CONTROL:     s_axi_rdata <= {24'h0, pwr_view};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // power modes
    wire in_run    = (mode == PM_RUN);
    wire regs_live = (mode == PM_RUN) || (mode == PM_WAIT);
    wire tb_runs   = (mode != PM_HALT);
    wire wdg_on    = wdg_activate || hw_wdg;
    wire tb_elapsed;
    wire tb_irq_event = tb_elapsed && tb_irq_en && !irq_mask;
    wire halt_cmd  = wr_pwr && in_run && wr_data[PWR_HALT_BIT];
    wire wait_cmd  = wr_pwr && in_run && wr_data[PWR_WAIT_BIT] && !wr_data[PWR_HALT_BIT];
    // halt with the watchdog on and no timed sleep resets only when the halt reset option is set
    wire halt_reset = halt_cmd && wdg_on && !tb_irq_en && hopt;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode <= PM_RUN;
        end else begin
            case (mode)
                PM_RUN: begin
                    if (halt_cmd) begin
                        mode <= tb_irq_en ? PM_TIMED_SLEEP : PM_HALT;
                    end else if (wait_cmd) begin
                        mode <= PM_WAIT;
                    end
                end
                PM_WAIT: begin
                    if (tb_irq_event || ext_wake) begin
                        mode <= PM_RUN;
                    end
                end
                PM_TIMED_SLEEP: begin
                    if (tb_irq_event || ext_wake) begin
                        mode <= PM_RUN;
                    end
                end
                PM_HALT: begin
                    if (ext_wake) begin
                        mode <= PM_RUN;
                    end
                end
                default: mode <= PM_RUN;
            endcase
        end
    end
    assign o_power_mode = mode;

    timebase_divider #(
        .P0 (PRESCALE_0),
        .P1 (PRESCALE_1),
        .P2 (PRESCALE_2),
        .P3 (PRESCALE_3)
    ) u_divider (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_run      (tb_runs),
        .i_select   (tb_select),
        .o_elapsed  (tb_elapsed)
    );

    // time-base control/status
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tb_select <= TB_CSR_RESET[TB_SEL_LSB +: 2];
            tb_irq_en <= TB_CSR_RESET[TB_IRQ_EN_BIT];
            tb_flag   <= TB_CSR_RESET[TB_FLAG_BIT];
        end else begin
            if (wr_tb && regs_live) begin
                tb_select <= wr_data[TB_SEL_LSB +: 2];
                tb_irq_en <= wr_data[TB_IRQ_EN_BIT];
            end
            // set beats the read-clear in the same cycle; timed sleep still records the wake event
            if (tb_elapsed && (regs_live || tb_irq_event)) begin
                tb_flag <= 1'b1;
            end else if (rd_tb) begin
                tb_flag <= 1'b0;
            end
        end
    end
    assign o_timebase_irq = tb_flag && tb_irq_en && !irq_mask;

    // watchdog
    wire step_end = (step_cnt == STEP_W'(WDG_STEP - 1));
    wire wdg_tick = wdg_on && step_end && (mode != PM_HALT) && (mode != PM_TIMED_SLEEP);
    wire expire   = wdg_tick && (countdown == WDG_EXPIRE_FROM);
    wire sw_reset = wr_wdg && wr_data[WDG_ACTIVATE_BIT] && !wr_data[WDG_MSB_BIT];
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wdg_activate <= WDG_CTRL_RESET[WDG_ACTIVATE_BIT];
            countdown    <= WDG_CTRL_RESET[6:0];
            step_cnt     <= '0;
        end else begin
            if (mode != PM_HALT && mode != PM_TIMED_SLEEP) begin
                step_cnt <= step_end ? '0 : step_cnt + 1'b1;
            end
            if (wr_wdg) begin
                wdg_activate <= wdg_activate | wr_data[WDG_ACTIVATE_BIT];
                countdown    <= wr_data[6:0];
            end else if (wdg_tick) begin
                countdown <= countdown - 7'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reset_request <= 1'b0;
        end else begin
            // level until the system reset pulls i_nrst; shaping lives outside
            o_reset_request <= o_reset_request || (wdg_on && (expire || halt_reset))
                               || sw_reset;
        end
    end
endmodule

// ---- dv/watchdog_timebase_sva.sv ----
`timescale 1ns/10ps
module watchdog_timebase_sva
    import wdt_tb_pkg::*;
#(
    parameter int PRESCALE_3 = TB_PRESCALE_3
) (
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_global_irq_mask,
    input wire logic        i_ext_wakeup,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        o_timebase_irq,
    input wire logic        o_reset_request,
    input wire logic [1:0]  o_power_mode
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    int unsigned sleep_cnt;
    // counter, since the longest period is far beyond any delay range
    always_ff @(posedge i_core_clk or negedge i_nrst)
        if (!i_nrst)
            sleep_cnt <= 0;
        else if (o_power_mode == PM_TIMED_SLEEP)
            sleep_cnt <= sleep_cnt + 1;
        else
            sleep_cnt <= 0;
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wdg_kill;
        wr_take ##0 (s_axi_awaddr == ADDR_WATCHDOG_CONTROL && s_axi_wstrb[0]
            && s_axi_wdata[7:6] == 2'b10);
    endsequence
    sequence rd_csr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_TIMEBASE_CTRL_STS;
    endsequence
    a_req_sticky: assert property (o_reset_request |=> o_reset_request)
        else $error("reset request dropped");
    a_sw_reset: assert property (wdg_kill |-> ##[1:3] o_reset_request)
        else $error("software reset not requested");
    a_irq_masked: assert property (i_global_irq_mask [*3] |-> ##1 !o_timebase_irq)
        else $error("interrupt while masked");
    a_halt_holds: assert property (o_power_mode == PM_HALT && !i_ext_wakeup
        && !$past(i_ext_wakeup) && !$past(i_ext_wakeup, 2) |=> o_power_mode == PM_HALT)
        else $error("halt left without wake-up");
    a_sleep_bound: assert property (sleep_cnt <= PRESCALE_3 + 4)
        else $error("timed sleep not ended by period");
    a_csr_reserved: assert property (rd_csr |=> s_axi_rdata[31:4] == 28'h0)
        else $error("reserved csr bits not zero");
    a_write_resp: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response missing");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule

bind watchdog_timebase watchdog_timebase_sva #(.PRESCALE_3(PRESCALE_3)) u_sva (
    .i_core_clk, .i_nrst, .i_global_irq_mask, .i_ext_wakeup, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .o_timebase_irq, .o_reset_request, .o_power_mode);

// ---- dv/tb_watchdog_timebase.sv ----
`timescale 1ns/10ps
module tb_watchdog_timebase;
    import wdt_tb_pkg::*;
    localparam int WS = 16;
    localparam int PS [4] = '{20, 40, 100, 250};
    logic        i_core_clk, i_nrst, i_hw_watchdog, i_halt_reset_option;
    logic        i_global_irq_mask, i_ext_wakeup, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, o_timebase_irq, o_reset_request;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, o_power_mode;
    int          err_count, checked, cyc, seed, m_sel, m_ie, t0, t1, old, k;
    watchdog_timebase #(.WDG_STEP(WS), .PRESCALE_0(PS[0]), .PRESCALE_1(PS[1]),
                        .PRESCALE_2(PS[2]), .PRESCALE_3(PS[3])) uut (
        .i_core_clk, .i_nrst, .i_hw_watchdog, .i_halt_reset_option, .i_global_irq_mask,
        .i_ext_wakeup, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_timebase_irq, .o_reset_request,
        .o_power_mode);
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) cyc <= cyc + 1;
    task automatic end_sim();
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // ready is sampled at the falling edge, where it is settled, and acted on next rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw;
        @(posedge i_core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge i_core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge i_core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid & ~ta | s_axi_wvalid & ~tw);
        do @(negedge i_core_clk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", AXI_OKAY, s_axi_bresp);
        @(posedge i_core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        @(posedge i_core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge i_core_clk); while (s_axi_arready !== 1'b1);
        @(posedge i_core_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge i_core_clk); while (s_axi_rvalid !== 1'b1);
        chk(n, e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge i_core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic set_csr(input int s, input int ie);
        m_sel = s;
        m_ie = ie;
        wr(ADDR_TIMEBASE_CTRL_STS, {4'h0, s[1:0], ie[0], 1'b0});
    endtask
    task automatic csr_chk(input int f);
        rchk("csr", ADDR_TIMEBASE_CTRL_STS, {28'h0, m_sel[1:0], m_ie[0], f[0]}, AXI_OKAY);
    endtask
    task automatic wait_irq(output int t);
        do @(negedge i_core_clk); while (o_timebase_irq !== 1'b1);
        t = cyc;
    endtask
    task automatic rst(input logic hw);
        @(posedge i_core_clk);
        i_nrst <= 1'b0;
        i_hw_watchdog <= hw;
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        m_sel = 0;
        m_ie = 0;
    endtask
    task automatic req_chk(input string n, input int c, input logic e);
        repeat (c) @(negedge i_core_clk);
        chk(n, e, o_reset_request);
    endtask
    initial begin
        repeat (30000) @(posedge i_core_clk);
        err_count++;
        end_sim();
    end
    initial begin
        seed = 24403;
        i_nrst = 1'b0;
        {i_hw_watchdog, i_halt_reset_option, i_global_irq_mask, i_ext_wakeup} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rchk("wdg reset", ADDR_WATCHDOG_CONTROL, 32'h7f, AXI_OKAY);
        csr_chk(0);
        rchk("unmapped", 8'h30, 32'h0, AXI_SLVERR);
        set_csr(0, 1);
        wait_irq(t0);
        csr_chk(1);
        wait_irq(t0);
        csr_chk(1);
        old = 0;
        for (k = 0; k < 5; k++) begin
            set_csr($random(seed) & 3, 1);
            wait_irq(t1);
            chk("old period", PS[old], t1 - t0);
            csr_chk(1);
            csr_chk(0);
            wait_irq(t0);
            chk("new period", PS[m_sel], t0 - t1);
            csr_chk(1);
            old = m_sel;
        end
        i_global_irq_mask <= 1'b1;
        repeat (PS[old] + 4) @(negedge i_core_clk);
        chk("masked irq", 0, o_timebase_irq);
        csr_chk(1);
        i_global_irq_mask <= 1'b0;
        wr(ADDR_POWER_CONTROL, 8'h02);
        chk("wait mode", PM_WAIT, o_power_mode);
        wait_irq(t1);
        repeat (3) @(negedge i_core_clk);
        chk("wait exit", PM_RUN, o_power_mode);
        csr_chk(1);
        wr(ADDR_POWER_CONTROL, 8'h01);
        chk("sleep mode", PM_TIMED_SLEEP, o_power_mode);
        repeat (PS[old] + 6) @(negedge i_core_clk);
        chk("sleep exit", PM_RUN, o_power_mode);
        csr_chk(1);
        set_csr(old, 0);
        wr(ADDR_POWER_CONTROL, 8'h01);
        repeat (PS[old] * 2) @(negedge i_core_clk);
        chk("halt held", PM_HALT, o_power_mode);
        @(posedge i_core_clk);
        i_ext_wakeup <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_ext_wakeup <= 1'b0;
        @(negedge i_core_clk);
        chk("halt exit", PM_RUN, o_power_mode);
        wr(ADDR_WATCHDOG_CONTROL, 8'h41);
        req_chk("inactive wdg", 3 * WS + 8, 1'b0);
        wr(ADDR_WATCHDOG_CONTROL, 8'h00);
        req_chk("no sw reset", 4, 1'b0);
        wr(ADDR_WATCHDOG_CONTROL, 8'hc2);
        req_chk("early expiry", 2 * WS - 3, 1'b0);
        req_chk("expiry", WS + 10, 1'b1);
        rst(1'b0);
        rchk("wdg after reset", ADDR_WATCHDOG_CONTROL, 32'h7f, AXI_OKAY);
        csr_chk(0);
        wr(ADDR_WATCHDOG_CONTROL, 8'h80);
        req_chk("sw reset", 3, 1'b1);
        rst(1'b0);
        i_halt_reset_option <= 1'b1;
        wr(ADDR_WATCHDOG_CONTROL, 8'hff);
        wr(ADDR_POWER_CONTROL, 8'h01);
        req_chk("halt reset", 3, 1'b1);
        rst(1'b1);
        wr(ADDR_WATCHDOG_CONTROL, 8'h41);
        req_chk("hw watchdog", 2 * WS + 6, 1'b1);
        end_sim();
    end
endmodule
